// ### rtc_pkg.sv
// constants, register map and field layouts of the real-time counter block
package rtc_pkg;

	// register indices; byte address is four times the index
	localparam logic [4:0] IDX_CTRL_A    = 5'h00;
	localparam logic [4:0] IDX_STATUS    = 5'h01;
	localparam logic [4:0] IDX_INT_EN    = 5'h02;
	localparam logic [4:0] IDX_INT_FLAGS = 5'h03;
	localparam logic [4:0] IDX_TEMP      = 5'h04;
	localparam logic [4:0] IDX_DBG       = 5'h05;
	localparam logic [4:0] IDX_CLK_SEL   = 5'h07;
	localparam logic [4:0] IDX_CNT_L     = 5'h08;
	localparam logic [4:0] IDX_CNT_H     = 5'h09;
	localparam logic [4:0] IDX_PER_L     = 5'h0A;
	localparam logic [4:0] IDX_PER_H     = 5'h0B;
	localparam logic [4:0] IDX_CMP_L     = 5'h0C;
	localparam logic [4:0] IDX_CMP_H     = 5'h0D;
	localparam logic [4:0] IDX_PIT_CTRL  = 5'h10;
	localparam logic [4:0] IDX_PIT_STAT  = 5'h11;
	localparam logic [4:0] IDX_PIT_EN    = 5'h12;
	localparam logic [4:0] IDX_PIT_FLAG  = 5'h13;
	localparam logic [4:0] IDX_PIT_DBG   = 5'h15;

	// bit positions in the flag, enable, busy and debug registers
	localparam int WRAP_BIT      = 0;
	localparam int CMP_BIT       = 1;
	localparam int BUSY_CTRL_BIT = 0;
	localparam int BUSY_CNT_BIT  = 1;
	localparam int BUSY_PER_BIT  = 2;
	localparam int BUSY_CMP_BIT  = 3;
	localparam int DBG_RUN_BIT   = 0;
	localparam int PERIODIC_BIT  = 0;

	// reset values
	localparam logic [7:0]  CTRL_RST = 8'h00;
	localparam logic [7:0]  BYTE_RST = 8'h00;
	localparam logic [15:0] CNT_RST  = 16'h0000;
	localparam logic [15:0] PER_RST  = 16'hFFFF;
	localparam logic [15:0] CMP_RST  = 16'h0000;

	// clock source codes
	localparam logic [1:0] SRC_INT_32768 = 2'h0;
	localparam logic [1:0] SRC_INT_1024  = 2'h1;
	localparam logic [1:0] SRC_EXTERNAL  = 2'h3;

	// periodic timer period codes
	localparam logic [3:0] PIT_OFF        = 4'h0;
	localparam logic [3:0] PIT_PERIOD_MAX = 4'hE;

	// rtc clock cycles from a register update to its effect
	localparam logic [1:0] SYNC_TICKS = 2'h2;

	typedef struct packed {
		logic       run_in_standby;
		logic [3:0] prescaler;
		logic [1:0] spare;
		logic       counter_enable;
	} ctrl_a_t;

	typedef struct packed {
		logic       spare_hi;
		logic [3:0] period;
		logic [1:0] spare_lo;
		logic       periodic_timer_enable;
	} pit_ctrl_t;

endpackage

// ### rtc_sync_stage.sv
// busy tracker for one register crossing into the rtc clock cadence
`timescale 1ns/1ps
`default_nettype none
module rtc_sync_stage (
	input  wire logic clk_in,
	input  wire logic arst_n_in,
	input  wire logic load_in,
	input  wire logic tick_in,
	output var  logic busy_out,
	output wire logic apply_out
);
	logic [1:0] ticks;

	// value is handed over on the second rtc tick after the write
	assign apply_out = busy_out & tick_in & ~load_in
		& (ticks == rtc_pkg::SYNC_TICKS - 2'h1);

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			busy_out <= 1'b0;
			ticks    <= 2'h0;
		end else if (load_in) begin
			busy_out <= 1'b1;
			ticks    <= 2'h0;
		end else if (apply_out) begin
			busy_out <= 1'b0;
		end else if (busy_out && tick_in) begin
			ticks <= ticks + 2'h1;
		end
	end
endmodule
`default_nettype wire

// ### rtc_register_control.sv
// real-time counter with periodic timer, register file and interrupt
`timescale 1ns/1ps
`default_nettype none
module rtc_register_control (
	input  wire logic        clk_in,
	input  wire logic        arst_n_in,
	input  wire logic [7:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output var  logic [31:0] avs_readdata_out,
	output wire logic        avs_waitrequest_out,
	input  wire logic        osc_32768_hz_in,
	input  wire logic        osc_1024_hz_in,
	input  wire logic        ext_clock_in,
	input  wire logic        standby_in,
	input  wire logic        debug_halt_in,
	output wire logic        irq_out,
	output var  logic        wrap_overflow_event_out,
	output var  logic        compare_match_event_out
);
	// bus
	logic                ack;
	logic [4:0]          idx;
	logic                rd_go;
	logic                wr_go;
	logic [7:0]          wbyte;
	logic [7:0]          rbyte;
	// software-side registers
	rtc_pkg::ctrl_a_t    ctrl_shadow;
	rtc_pkg::ctrl_a_t    ctrl_active;
	rtc_pkg::pit_ctrl_t  pit_shadow;
	rtc_pkg::pit_ctrl_t  pit_active;
	logic [1:0]          int_enable;
	logic [1:0]          int_flags;
	logic                pit_int_enable;
	logic                pit_flag;
	logic [7:0]          temp_byte;
	logic                run_during_break;
	logic                pit_run_during_break;
	logic [1:0]          clock_source_field;
	logic [15:0]         cnt_shadow;
	logic [15:0]         per_shadow;
	logic [15:0]         cmp_shadow;
	logic [15:0]         count;
	logic [15:0]         period_value;
	logic [15:0]         compare_value;
	// rtc cadence
	logic [2:0]          src_meta;
	logic [2:0]          src_sync;
	logic                src_prev;
	logic                src_sel;
	logic                rtc_tick;
	logic [14:0]         presc;
	logic [14:0]         div_mask;
	logic                presc_on;
	logic                count_run;
	logic                count_tick;
	logic                pit_halt;
	logic                pit_level;
	logic                pit_prev;
	logic                pit_set;
	logic                wrap_hit;
	logic                cmp_hit;
	logic [1:0]          next_int_flags;
	logic                next_pit_flag;
	// sync trackers
	logic [4:0]          sync_load;
	logic [4:0]          sync_busy;
	logic [4:0]          sync_apply;
	logic [7:0]          status_byte;

	// bus handshake: one wait cycle, then the answer
	assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack;
	assign idx   = avs_address_in[6:2];
	assign rd_go = avs_read_in & ~ack & ~avs_address_in[7];
	assign wr_go = avs_write_in & ack & avs_byteenable_in[0] & ~avs_address_in[7];
	assign wbyte = avs_writedata_in[7:0];

	wire wr_ctrl     = wr_go & (idx == rtc_pkg::IDX_CTRL_A);
	wire wr_int_en   = wr_go & (idx == rtc_pkg::IDX_INT_EN);
	wire wr_flags    = wr_go & (idx == rtc_pkg::IDX_INT_FLAGS);
	wire wr_temp     = wr_go & (idx == rtc_pkg::IDX_TEMP);
	wire wr_dbg      = wr_go & (idx == rtc_pkg::IDX_DBG);
	wire wr_clk_sel  = wr_go & (idx == rtc_pkg::IDX_CLK_SEL);
	wire wr_cnt_l    = wr_go & (idx == rtc_pkg::IDX_CNT_L);
	wire wr_cnt_h    = wr_go & (idx == rtc_pkg::IDX_CNT_H);
	wire wr_per_l    = wr_go & (idx == rtc_pkg::IDX_PER_L);
	wire wr_per_h    = wr_go & (idx == rtc_pkg::IDX_PER_H);
	wire wr_cmp_l    = wr_go & (idx == rtc_pkg::IDX_CMP_L);
	wire wr_cmp_h    = wr_go & (idx == rtc_pkg::IDX_CMP_H);
	wire wr_pit_ctrl = wr_go & (idx == rtc_pkg::IDX_PIT_CTRL);
	wire wr_pit_en   = wr_go & (idx == rtc_pkg::IDX_PIT_EN);
	wire wr_pit_flag = wr_go & (idx == rtc_pkg::IDX_PIT_FLAG);
	wire wr_pit_dbg  = wr_go & (idx == rtc_pkg::IDX_PIT_DBG);
	wire rd_cnt_l    = rd_go & (idx == rtc_pkg::IDX_CNT_L);
	wire rd_per_l    = rd_go & (idx == rtc_pkg::IDX_PER_L);
	wire rd_cmp_l    = rd_go & (idx == rtc_pkg::IDX_CMP_L);

	// busy bits in their documented positions
	assign status_byte = {4'h0, sync_busy[3:0]};

	always_comb begin
		rbyte = 8'h00;
		if (!avs_address_in[7]) begin
			unique case (idx)
				rtc_pkg::IDX_CTRL_A:    rbyte = ctrl_shadow;
				rtc_pkg::IDX_STATUS:    rbyte = status_byte;
				rtc_pkg::IDX_INT_EN:    rbyte = {6'h00, int_enable};
				rtc_pkg::IDX_INT_FLAGS: rbyte = {6'h00, int_flags};
				rtc_pkg::IDX_TEMP:      rbyte = temp_byte;
				rtc_pkg::IDX_DBG:       rbyte = {7'h00, run_during_break};
				rtc_pkg::IDX_CLK_SEL:   rbyte = {6'h00, clock_source_field};
				rtc_pkg::IDX_CNT_L:     rbyte = count[7:0];
				rtc_pkg::IDX_PER_L:     rbyte = per_shadow[7:0];
				rtc_pkg::IDX_CMP_L:     rbyte = cmp_shadow[7:0];
				rtc_pkg::IDX_CNT_H,
				rtc_pkg::IDX_PER_H,
				rtc_pkg::IDX_CMP_H:     rbyte = temp_byte;
				rtc_pkg::IDX_PIT_CTRL:  rbyte = pit_shadow;
				rtc_pkg::IDX_PIT_STAT:  rbyte = {7'h00, sync_busy[4]};
				rtc_pkg::IDX_PIT_EN:    rbyte = {7'h00, pit_int_enable};
				rtc_pkg::IDX_PIT_FLAG:  rbyte = {7'h00, pit_flag};
				rtc_pkg::IDX_PIT_DBG:   rbyte = {7'h00, pit_run_during_break};
				default:                rbyte = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ack              <= 1'b0;
			avs_readdata_out <= 32'h0000_0000;
		end else begin
			ack <= (avs_read_in | avs_write_in) & ~ack;
			if (avs_read_in && !ack) begin
				avs_readdata_out <= {24'h00_0000, rbyte};
			end
		end
	end

	// temporary byte: low read latches high half, low write parks data
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			temp_byte <= rtc_pkg::BYTE_RST;
		end else if (wr_temp || wr_cnt_l || wr_per_l || wr_cmp_l) begin
			temp_byte <= wbyte;
		end else if (rd_cnt_l) begin
			temp_byte <= count[15:8];
		end else if (rd_per_l) begin
			temp_byte <= per_shadow[15:8];
		end else if (rd_cmp_l) begin
			temp_byte <= cmp_shadow[15:8];
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ctrl_shadow          <= rtc_pkg::CTRL_RST;
			pit_shadow           <= rtc_pkg::CTRL_RST;
			int_enable           <= 2'h0;
			pit_int_enable       <= 1'b0;
			run_during_break     <= 1'b0;
			pit_run_during_break <= 1'b0;
			clock_source_field   <= rtc_pkg::SRC_INT_32768;
			cnt_shadow           <= rtc_pkg::CNT_RST;
			per_shadow           <= rtc_pkg::PER_RST;
			cmp_shadow           <= rtc_pkg::CMP_RST;
		end else begin
			if (wr_ctrl) ctrl_shadow <= wbyte;
			if (wr_pit_ctrl) pit_shadow <= wbyte;
			if (wr_int_en) int_enable <= wbyte[1:0];
			if (wr_pit_en) pit_int_enable <= wbyte[rtc_pkg::PERIODIC_BIT];
			if (wr_dbg) run_during_break <= wbyte[rtc_pkg::DBG_RUN_BIT];
			if (wr_pit_dbg) pit_run_during_break <= wbyte[rtc_pkg::DBG_RUN_BIT];
			if (wr_clk_sel) clock_source_field <= wbyte[1:0];
			// high-byte write commits both halves at once
			if (wr_cnt_h) cnt_shadow <= {wbyte, temp_byte};
			if (wr_per_h) per_shadow <= {wbyte, temp_byte};
			if (wr_cmp_h) cmp_shadow <= {wbyte, temp_byte};
		end
	end

	// busy trackers, one per synchronised register
	assign sync_load = {wr_pit_ctrl, wr_cmp_h, wr_per_h, wr_cnt_h, wr_ctrl};

	genvar g;
	generate
		for (g = 0; g < 5; g++) begin : g_sync
			rtc_sync_stage u_stage (
				.clk_in    (clk_in),
				.arst_n_in (arst_n_in),
				.load_in   (sync_load[g]),
				.tick_in   (rtc_tick),
				.busy_out  (sync_busy[g]),
				.apply_out (sync_apply[g])
			);
		end
	endgenerate

	// applied copies follow the shadows two rtc cycles late
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ctrl_active   <= rtc_pkg::CTRL_RST;
			pit_active    <= rtc_pkg::CTRL_RST;
			period_value  <= rtc_pkg::PER_RST;
			compare_value <= rtc_pkg::CMP_RST;
		end else begin
			if (sync_apply[rtc_pkg::BUSY_CTRL_BIT]) ctrl_active <= ctrl_shadow;
			if (sync_apply[4]) pit_active <= pit_shadow;
			if (sync_apply[rtc_pkg::BUSY_PER_BIT]) period_value <= per_shadow;
			if (sync_apply[rtc_pkg::BUSY_CMP_BIT]) compare_value <= cmp_shadow;
		end
	end

	// oscillator pins are asynchronous: two flops before anything looks
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			src_meta <= 3'h0;
			src_sync <= 3'h0;
			src_prev <= 1'b0;
		end else begin
			src_meta <= {ext_clock_in, osc_1024_hz_in, osc_32768_hz_in};
			src_sync <= src_meta;
			src_prev <= src_sel;
		end
	end

	// source select; reserved code gives no clock
	assign src_sel = (clock_source_field == rtc_pkg::SRC_INT_32768) ? src_sync[0]
		: (clock_source_field == rtc_pkg::SRC_INT_1024) ? src_sync[1]
		: (clock_source_field == rtc_pkg::SRC_EXTERNAL) ? src_sync[2] : 1'b0;
	// a source switch may cost or add one tick; software changes it while idle
	assign rtc_tick = src_sel & ~src_prev;

	// debug break halts each part unless it may run on
	wire cnt_halt = debug_halt_in & ~run_during_break;
	assign pit_halt = debug_halt_in & ~pit_run_during_break;

	// shared prescaler runs while either function is enabled, unless a debug break halts both parts
	assign presc_on = ctrl_active.counter_enable | pit_active.periodic_timer_enable;

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			presc <= 15'h0000;
		end else if (presc_on && rtc_tick && !(cnt_halt && pit_halt)) begin
			presc <= presc + 15'h0001;
		end
	end

	assign count_run = ctrl_active.counter_enable & ~cnt_halt
		& ~(standby_in & ~ctrl_active.run_in_standby);
	// divide by two to the prescaler code
	assign div_mask   = ~(15'h7FFF << ctrl_active.prescaler);
	assign count_tick = rtc_tick & count_run & ((presc & div_mask) == div_mask);
	assign wrap_hit   = count_tick & (count == period_value);
	assign cmp_hit    = count_tick & (count == compare_value);

	// wrap to zero after the period value
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			count <= rtc_pkg::CNT_RST;
		end else if (sync_apply[rtc_pkg::BUSY_CNT_BIT]) begin
			count <= cnt_shadow;
		end else if (wrap_hit) begin
			count <= 16'h0000;
		end else if (count_tick) begin
			count <= count + 16'h0001;
		end
	end

	// periodic output follows prescaler bit picked by the period code
	assign pit_level = pit_active.periodic_timer_enable & ~pit_halt
		& (pit_active.period != rtc_pkg::PIT_OFF)
		& (pit_active.period <= rtc_pkg::PIT_PERIOD_MAX)
		& presc[pit_active.period];
	assign pit_set = pit_level & ~pit_prev;

	// flags: a set in the clearing cycle wins
	assign next_int_flags = (int_flags & ~(wr_flags ? wbyte[1:0] : 2'h0))
		| {cmp_hit, wrap_hit};
	assign next_pit_flag = (pit_flag & ~(wr_pit_flag & wbyte[rtc_pkg::PERIODIC_BIT])) | pit_set;

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			int_flags               <= 2'h0;
			pit_flag                <= 1'b0;
			pit_prev                <= 1'b0;
			wrap_overflow_event_out <= 1'b0;
			compare_match_event_out <= 1'b0;
		end else begin
			int_flags               <= next_int_flags;
			pit_flag                <= next_pit_flag;
			pit_prev                <= pit_level;
			wrap_overflow_event_out <= wrap_hit;
			compare_match_event_out <= cmp_hit;
		end
	end

	// enabled and flagged sources drive the request
	assign irq_out = |(int_flags & int_enable) | (pit_flag & pit_int_enable);

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);

	a_busy_rise: assert property (wr_ctrl |=> sync_busy[0])
		else $error("control busy did not rise after write");
	a_ctrl_apply: assert property ($fell(sync_busy[0]) && !$past(wr_ctrl) |-> ctrl_active == $past(ctrl_shadow))
		else $error("control value not applied when busy fell");
	a_busy_two_ticks: assert property (wr_ctrl ##1 (!rtc_tick && !wr_ctrl)[*2] |-> sync_busy[0])
		else $error("control busy fell without rtc ticks");
	a_disabled_hold: assert property (!ctrl_active.counter_enable && !sync_apply[1] |=> $stable(count))
		else $error("counter moved while disabled");
	a_standby_hold: assert property (standby_in && !ctrl_active.run_in_standby && !sync_apply[1]
		|=> $stable(count))
		else $error("counter moved in standby");
	a_wrap_zero: assert property (wrap_hit && !sync_apply[1] |=> count == 16'h0000 && int_flags[0])
		else $error("no wrap to zero with overflow flag");
	a_cmp_flag: assert property (cmp_hit |=> int_flags[1] ##1 compare_match_event_out == 1'b0)
		else $error("compare flag not set");
	a_set_wins: assert property (wrap_hit && wr_flags && wbyte[0] |=> int_flags[0])
		else $error("overflow lost to clear");
	a_irq_level: assert property (int_flags[1] && int_enable[1] |-> irq_out)
		else $error("irq low with enabled compare flag");
	a_presc_off: assert property (!presc_on |=> $stable(presc))
		else $error("prescaler ran while both functions off");
	a_pit_off: assert property (pit_active.period == rtc_pkg::PIT_OFF |-> !pit_set)
		else $error("periodic interrupt with period off");
	c_overflow: cover property (wrap_hit ##1 irq_out);
	c_compare: cover property (cmp_hit);
	c_periodic: cover property (pit_set ##[1:20] wr_pit_flag);
endmodule
`default_nettype wire

// ### rtc_cpu_master.sv
// cpu-side avalon master model that drives the register bus of the counter block
`timescale 1ns/1ps
`default_nettype none
module rtc_cpu_master (
	input  wire logic        clk_in,
	input  wire logic        waitrequest_in,
	input  wire logic [31:0] readdata_in,
	output var  logic [7:0]  address_out,
	output var  logic        read_out,
	output var  logic        write_out,
	output var  logic [31:0] writedata_out,
	output var  logic [3:0]  byteenable_out,
	output var  logic        timed_out_out
);
	initial begin
		address_out = 8'h00;
		read_out = 1'b0;
		write_out = 1'b0;
		writedata_out = 32'h00000000;
		byteenable_out = 4'h0;
		timed_out_out = 1'b0;
	end

	// one bus cycle: the request stands until waitrequest is seen low at a rising edge
	task automatic xfer(input logic wr, input logic [4:0] idx, input logic [7:0] dat, input logic [3:0] ben,
		output logic [7:0] q);
		int n;
		@(posedge clk_in);
		address_out <= {1'b0, idx, 2'b00};
		read_out <= ~wr;
		write_out <= wr;
		writedata_out <= {24'h000000, dat};
		byteenable_out <= ben;
		// waitrequest is read before this edge's updates land, so it is what the slave shows at the edge
		for (n = 0; n < 20; n++) begin
			@(posedge clk_in);
			if (waitrequest_in === 1'b0) break;
		end
		q = readdata_in[7:0];
		if (n == 20) timed_out_out = 1'b1;
		read_out <= 1'b0;
		write_out <= 1'b0;
		// released lines carry the inverse, so a stale value is never mistaken for a live one
		address_out <= ~address_out;
		writedata_out <= ~writedata_out;
		byteenable_out <= ~byteenable_out;
	endtask
endmodule
`default_nettype wire

// ### rtc_register_control_test.sv
// self-checking bench for the real-time counter register block
`timescale 1ns/1ps
`default_nettype none
module rtc_register_control_test;
	logic        clk_in = 1'b0;
	logic        arst_n_in = 1'b0;
	logic [2:0]  osc = 3'h0;
	logic        standby = 1'b0;
	logic        halt = 1'b0;
	logic [7:0]  address;
	logic        rd_req;
	logic        wr_req;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [3:0]  be;
	logic        waitreq;
	logic        irq;
	logic        wrap_ev;
	logic        match_ev;
	logic        tmo;
	logic [7:0]  v;
	logic [7:0]  w;
	logic [7:0]  d;
	int          ph = 0;
	int          n_errors = 0;
	int          cmp_count = 0;
	int          n_wraps = 0;
	int          n_matches = 0;
	int          exp_reg[int];
	int          src[4] = '{0, 1, 3, 2};
	logic [4:0]  zero_idx[7] = '{rtc_pkg::IDX_STATUS, rtc_pkg::IDX_INT_FLAGS, rtc_pkg::IDX_PIT_STAT,
		rtc_pkg::IDX_PIT_FLAG, rtc_pkg::IDX_CNT_L, 5'h06, 5'h0E};

	always #2.5 clk_in = ~clk_in;
	// sources of 8, 32 and 16 clocks a period; tick counts over a 44-cycle gap never land on a multiple of 4
	always @(posedge clk_in) begin
		ph <= ph + 1;
		osc <= {ph[3], ph[4], ph[2]};
		if (wrap_ev === 1'b1) n_wraps <= n_wraps + 1;
		if (match_ev === 1'b1) n_matches <= n_matches + 1;
	end

	rtc_cpu_master i_rtc_cpu_master (.clk_in(clk_in), .waitrequest_in(waitreq), .readdata_in(rdata),
		.address_out(address), .read_out(rd_req), .write_out(wr_req), .writedata_out(wdata),
		.byteenable_out(be), .timed_out_out(tmo));

	rtc_register_control i_rtc_register_control (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.avs_address_in(address), .avs_read_in(rd_req), .avs_write_in(wr_req), .avs_writedata_in(wdata),
		.avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
		.osc_32768_hz_in(osc[0]), .osc_1024_hz_in(osc[1]), .ext_clock_in(osc[2]), .standby_in(standby),
		.debug_halt_in(halt), .irq_out(irq), .wrap_overflow_event_out(wrap_ev),
		.compare_match_event_out(match_ev));

	task automatic give_verdict;
		if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task automatic check_reg(input string name, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic check_pin(input string name, input logic exp, input logic got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %b seen %b", name, exp, got);
		end
	endtask

	// irq follows registers combinationally, so it is looked at once the write edge has settled
	task automatic check_irq(input string name, input logic exp);
		@(negedge clk_in);
		check_pin(name, exp, irq);
	endtask

	task automatic bus(input logic wr, input logic [4:0] idx, input logic [7:0] dat, input logic [3:0] ben);
		i_rtc_cpu_master.xfer(wr, idx, dat, ben, v);
		if (tmo === 1'b1) begin
			n_errors++;
			give_verdict();
		end
	endtask

	task automatic wr_reg(input logic [4:0] idx, input logic [7:0] dat);
		bus(1'b1, idx, dat, 4'hF);
		if (exp_reg.exists(int'(idx))) exp_reg[int'(idx)] = int'(dat);
	endtask

	task automatic rd_chk(input string name, input logic [4:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h00, 4'hF);
		check_reg(name, exp, v);
		check_pin("upper read bits", 1'b0, |rdata[31:8]);
	endtask

	// polls until the masked bits match; the bound turns a stuck bit into a failure, not a hang
	task automatic wait_bits(input logic [4:0] idx, input logic [7:0] mask, input logic [7:0] want);
		int n;
		for (n = 0; n < 200; n++) begin
			bus(1'b0, idx, 8'h00, 4'hF);
			if ((v & mask) === want) break;
		end
		if (n == 200) begin
			n_errors++;
			give_verdict();
		end
	endtask

	task automatic count_moves(input string name, input logic moves);
		bus(1'b0, rtc_pkg::IDX_CNT_L, 8'h00, 4'hF);
		w = v;
		repeat (41) @(posedge clk_in);
		bus(1'b0, rtc_pkg::IDX_CNT_L, 8'h00, 4'hF);
		check_pin(name, moves, v !== w);
	endtask

	initial begin
		void'($urandom(32'h68fb372b));
		exp_reg[rtc_pkg::IDX_CTRL_A] = 0;
		exp_reg[rtc_pkg::IDX_INT_EN] = 0;
		exp_reg[rtc_pkg::IDX_TEMP] = 0;
		exp_reg[rtc_pkg::IDX_DBG] = 0;
		exp_reg[rtc_pkg::IDX_CLK_SEL] = 0;
		exp_reg[rtc_pkg::IDX_PIT_CTRL] = 0;
		exp_reg[rtc_pkg::IDX_PIT_EN] = 0;
		exp_reg[rtc_pkg::IDX_PIT_DBG] = 0;
		repeat (16) @(posedge clk_in);
		arst_n_in <= 1'b1;
		foreach (exp_reg[i]) rd_chk("reset value", 5'(i), 8'(exp_reg[i]));
		foreach (zero_idx[i]) rd_chk("reset zero", zero_idx[i], 8'h00);
		rd_chk("period low", rtc_pkg::IDX_PER_L, 8'hFF);
		rd_chk("period high", rtc_pkg::IDX_PER_H, 8'hFF);
		// shared byte, lane 0 off refused
		d = 8'($urandom);
		wr_reg(rtc_pkg::IDX_TEMP, d);
		bus(1'b1, rtc_pkg::IDX_TEMP, ~d, 4'hE);
		rd_chk("shared byte", rtc_pkg::IDX_TEMP, d);
		wr_reg(rtc_pkg::IDX_PER_L, 8'h03);
		wr_reg(rtc_pkg::IDX_PER_H, 8'h00);
		rd_chk("period busy", rtc_pkg::IDX_STATUS, 8'h04);
		wait_bits(rtc_pkg::IDX_STATUS, 8'h04, 8'h00);
		d = 8'($urandom_range(3));
		wr_reg(rtc_pkg::IDX_CMP_L, d);
		wr_reg(rtc_pkg::IDX_CMP_H, 8'h00);
		rd_chk("compare busy", rtc_pkg::IDX_STATUS, 8'h08);
		wait_bits(rtc_pkg::IDX_STATUS, 8'h08, 8'h00);
		rd_chk("compare low", rtc_pkg::IDX_CMP_L, d);
		rd_chk("compare high", rtc_pkg::IDX_CMP_H, 8'h00);
		rd_chk("period low", rtc_pkg::IDX_PER_L, 8'h03);
		wr_reg(rtc_pkg::IDX_INT_EN, 8'h03);
		wr_reg(rtc_pkg::IDX_CTRL_A, 8'h01);
		rd_chk("control busy", rtc_pkg::IDX_STATUS, 8'h01);
		wait_bits(rtc_pkg::IDX_STATUS, 8'h01, 8'h00);
		wait_bits(rtc_pkg::IDX_INT_FLAGS, 8'h03, 8'h03);
		check_irq("irq both", 1'b1);
		wr_reg(rtc_pkg::IDX_INT_EN, 8'h00);
		check_irq("irq masked", 1'b0);
		wr_reg(rtc_pkg::IDX_INT_EN, 8'h02);
		check_irq("irq match only", 1'b1);
		wr_reg(rtc_pkg::IDX_CTRL_A, 8'h00);
		wait_bits(rtc_pkg::IDX_STATUS, 8'h01, 8'h00);
		// counter stopped, so a flag that survives a zero write was kept, not set again
		wr_reg(rtc_pkg::IDX_INT_FLAGS, 8'h00);
		rd_chk("flags kept", rtc_pkg::IDX_INT_FLAGS, 8'h03);
		wr_reg(rtc_pkg::IDX_INT_FLAGS, 8'h01);
		rd_chk("wrap cleared", rtc_pkg::IDX_INT_FLAGS, 8'h02);
		wr_reg(rtc_pkg::IDX_INT_FLAGS, 8'h02);
		check_irq("irq cleared", 1'b0);
		wr_reg(rtc_pkg::IDX_INT_EN, 8'h00);
		check_pin("wrap events", 1'b1, n_wraps > 0);
		check_pin("match events", 1'b1, n_matches > 0);
		count_moves("disabled", 1'b0);
		// standby with and without run bit
		standby <= 1'b1;
		wr_reg(rtc_pkg::IDX_CTRL_A, 8'h01);
		wait_bits(rtc_pkg::IDX_STATUS, 8'h01, 8'h00);
		count_moves("standby stop", 1'b0);
		wr_reg(rtc_pkg::IDX_CTRL_A, 8'h81);
		wait_bits(rtc_pkg::IDX_STATUS, 8'h01, 8'h00);
		count_moves("standby run", 1'b1);
		standby <= 1'b0;
		halt <= 1'b1;
		count_moves("break halt", 1'b0);
		wr_reg(rtc_pkg::IDX_DBG, 8'h01);
		count_moves("break run", 1'b1);
		halt <= 1'b0;
		foreach (src[i]) begin
			wr_reg(rtc_pkg::IDX_CLK_SEL, 8'(src[i]));
			count_moves("source", src[i] != 2);
		end
		wr_reg(rtc_pkg::IDX_CLK_SEL, 8'h00);
		wr_reg(rtc_pkg::IDX_CTRL_A, 8'h79);
		wait_bits(rtc_pkg::IDX_STATUS, 8'h01, 8'h00);
		count_moves("slowest division", 1'b0);
		// counter write through the shared byte
		d = 8'($urandom);
		wr_reg(rtc_pkg::IDX_CNT_L, d);
		wr_reg(rtc_pkg::IDX_CNT_H, 8'h00);
		rd_chk("count busy", rtc_pkg::IDX_STATUS, 8'h02);
		wait_bits(rtc_pkg::IDX_STATUS, 8'h02, 8'h00);
		rd_chk("count low", rtc_pkg::IDX_CNT_L, d);
		rd_chk("count high", rtc_pkg::IDX_CNT_H, 8'h00);
		wr_reg(rtc_pkg::IDX_PIT_EN, 8'h01);
		wr_reg(rtc_pkg::IDX_PIT_CTRL, 8'h09);
		rd_chk("periodic busy", rtc_pkg::IDX_PIT_STAT, 8'h01);
		wait_bits(rtc_pkg::IDX_PIT_STAT, 8'h01, 8'h00);
		wait_bits(rtc_pkg::IDX_PIT_FLAG, 8'h01, 8'h01);
		check_irq("irq periodic", 1'b1);
		wr_reg(rtc_pkg::IDX_PIT_CTRL, 8'h00);
		wait_bits(rtc_pkg::IDX_PIT_STAT, 8'h01, 8'h00);
		wr_reg(rtc_pkg::IDX_PIT_FLAG, 8'h01);
		rd_chk("periodic cleared", rtc_pkg::IDX_PIT_FLAG, 8'h00);
		check_irq("irq idle", 1'b0);
		wr_reg(rtc_pkg::IDX_TEMP, 8'($urandom));
		foreach (exp_reg[i]) rd_chk("readback", 5'(i), 8'(exp_reg[i]));
		give_verdict();
	end
endmodule
`default_nettype wire
